// *** core/marker_channel.sv ***
// one marker channel: offset, width, cycle counting and output polarity
`timescale 1ns/100ps
`default_nettype none
`include "marker_consts.svh"

module marker_channel #(
   parameter int CNT_W = `MK_CNT_W
) (
   input  wire logic               sys_clk,
   input  wire logic               rstn,
   input  wire logic               sampleEn,
   input  wire logic               patStart,
   input  wire logic               storedBit,
   input  wire marker_pkg::mode_t  mode,
   input  wire logic               offAllowed,
   input  wire logic               negPol,
   input  wire logic [CNT_W-1:0]   offset,
   input  wire logic [CNT_W-1:0]   width,
   input  wire logic [CNT_W-1:0]   cycle,
   input  wire logic [CNT_W-1:0]   patLen,
   output logic                    markerOut
);

   typedef struct packed {
      logic [CNT_W-1:0] pre;
      logic [CNT_W-1:0] phase;
      logic             running;
      logic             out;
   } chan_state_t;

   chan_state_t s_reg;
   chan_state_t s_next;

   // ----------------------------------------------------------------------
   // counting
   // ----------------------------------------------------------------------
   always_comb begin
      logic [CNT_W-1:0] period;
      logic [CNT_W-1:0] effW;
      logic [CNT_W-1:0] preS;
      logic [CNT_W-1:0] phS;
      logic             active;
      logic             lvl;
      lvl    = 1'b0;
      period = (mode == marker_pkg::MODE_SYNC) ? patLen : cycle;   // [RULE_03] [RULE_04]
      if (period == '0) period = CNT_W'(1);
      effW = (width > period) ? period : width;                    // [RULE_12] [RULE_13]
      if (effW == '0) effW = CNT_W'(1);                            // [RULE_11]
      // each pattern pass restarts the count at its own start
      preS   = patStart ? offset : s_reg.pre;                      // [RULE_09] [RULE_19]
      phS    = patStart ? '0 : s_reg.phase;
      active = (s_reg.running | patStart) && preS == '0 && phS < effW; // [RULE_18]
      case (mode)
         marker_pkg::MODE_OFF:  lvl = offAllowed & storedBit;      // [RULE_02] [RULE_06]
         marker_pkg::MODE_USER: lvl = active;                      // [RULE_05]
         marker_pkg::MODE_SYNC: lvl = active;                      // [RULE_05]
         default:               lvl = 1'b0;
      endcase
      s_next = s_reg;
      if (sampleEn) begin
         s_next.running = s_reg.running | patStart;
         if (preS != '0) begin
            s_next.pre   = preS - CNT_W'(1);
            s_next.phase = '0;
         end else begin
            s_next.pre   = '0;
            s_next.phase = (phS + CNT_W'(1) >= period) ? '0 : phS + CNT_W'(1);
         end
         s_next.out = lvl ^ negPol;                                // [RULE_15] [RULE_17]
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) s_reg <= '0;
      else       s_reg <= s_next;
   end

   assign markerOut = s_reg.out;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   AST_OUT_ONLY_ON_SAMPLE: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_16]
      !sampleEn |=> $stable(markerOut)) else $error("marker moved without a sample");
   AST_OFFSET_DELAYS: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_09]
      sampleEn && patStart && mode != marker_pkg::MODE_OFF && offset != '0
      |=> markerOut == $past(negPol)) else $error("marker active inside offset");
   AST_START_PULSE: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_04]
      sampleEn && patStart && mode != marker_pkg::MODE_OFF && offset == '0
      |=> markerOut == !$past(negPol)) else $error("no marker at pattern start");
   AST_PASS_THROUGH: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_02]
      sampleEn && mode == marker_pkg::MODE_OFF && offAllowed
      |=> markerOut == ($past(storedBit) ^ $past(negPol))) else $error("stored bit not passed");
   AST_NO_STORED_BITS: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_08]
      sampleEn && mode == marker_pkg::MODE_OFF && !offAllowed
      |=> markerOut == $past(negPol)) else $error("forbidden pass-through drove marker");

endmodule : marker_channel
`default_nettype wire

// *** core/marker_consts.svh ***
// offsets, field positions, reset values and counts of the marker pulse generator
`ifndef MARKER_CONSTS_SVH
`define MARKER_CONSTS_SVH

// ----------------------------------------------------------------------
// geometry
// ----------------------------------------------------------------------
`define MK_NUM_PAT     2
`define MK_PER_PAT     3
`define MK_NUM_CH      6
`define MK_CNT_W       24
`define MK_CNT_MAX     24'hffffff
`define MK_RATIO_W     8
`define MK_UNIT_DIV    40'h64
`define MK_UNIT_HALF   40'h32

// ----------------------------------------------------------------------
// register map, byte addresses
// ----------------------------------------------------------------------
`define MK_ADR_W       8
`define MK_OFS_CTRL    4'h0
`define MK_OFS_OFFSET  4'h4
`define MK_OFS_WIDTH   4'h8
`define MK_OFS_CYCLE   4'hc
`define MK_PAT_BASE    8'h60
`define MK_STATUS      8'h70

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define MK_CTRL_POL_BIT  4
`define MK_PCFG_RATIO_LSB 8
`define MK_STAT_REJ_BIT  8
`define MK_RST_OFFSET  24'h000000
`define MK_RST_WIDTH   24'h000001
`define MK_RST_CYCLE   24'h000001
`define MK_RST_PLEN    24'h000001
`define MK_RST_RATIO   8'h01

`endif

// *** core/marker_pkg.sv ***
// types shared by the marker pulse generator
`default_nettype none
package marker_pkg;
   typedef enum logic [1:0] {MODE_OFF, MODE_USER, MODE_SYNC} mode_t;
   typedef enum logic [1:0] {RES_14, RES_15, RES_16} res_t;
endpackage : marker_pkg
`default_nettype wire

// *** core/waveform_marker_pulse_gen.sv ***
// marker pulse generator top: wishbone registers and six marker channels
`timescale 1ns/100ps
`default_nettype none
`include "marker_consts.svh"

// Summary of operation
// RULE_01: three markers per pattern, six channels
// RULE_02: edit off passes stored marker bit
// RULE_03: user mode repeats pulse at user cycle
// RULE_04: sync mode repeats once per pattern pass
// RULE_05: edit modes ignore stored marker bits
// RULE_06: pass-through allowed for all at 14-bit
// RULE_07: 15-bit refuses pass-through on markers two, three
// RULE_08: 16-bit refuses pass-through on all markers
// RULE_09: offset delays pulse, 0 to 2^24-1 samples
// RULE_10: values written in hundredths of system units
// RULE_11: width at least one sample, default one unit
// RULE_12: user width capped by cycle and 2^24-1
// RULE_13: sync width capped by pattern length
// RULE_14: cycle one to 2^24-1 samples, default one
// RULE_15: per-channel selectable output polarity
// RULE_16: markers drive trigger outputs
// RULE_17: polarity resets positive, negative inverts
// RULE_18: active while phase after offset below width
// RULE_19: patterns A and B count independently
module waveform_marker_pulse_gen #(
   parameter int CNT_W   = `MK_CNT_W,
   parameter int RATIO_W = `MK_RATIO_W
) (
   input  wire logic                  sys_clk,
   input  wire logic                  rstn,
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [`MK_ADR_W-1:0]  wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic      [31:0]           wb_dat_o,
   output logic                       wb_ack_o,
   input  wire logic                  sampleEn,
   input  wire logic [1:0]            patStart,
   input  wire logic [5:0]            storedBits,
   output logic      [5:0]            markerOut
);

   typedef struct packed {
      logic                                  ack;
      logic [31:0]                           rdata;
      logic                                  rej;
      marker_pkg::mode_t [`MK_NUM_CH-1:0]    mode;
      logic [`MK_NUM_CH-1:0]                 neg;
      logic [`MK_NUM_CH-1:0][CNT_W-1:0]      offset;
      logic [`MK_NUM_CH-1:0][CNT_W-1:0]      width;
      logic [`MK_NUM_CH-1:0][CNT_W-1:0]      cycle;
      marker_pkg::res_t [`MK_NUM_PAT-1:0]    res;
      logic [`MK_NUM_PAT-1:0][RATIO_W-1:0]   ratio;
      logic [`MK_NUM_PAT-1:0][CNT_W-1:0]     plen;
   } top_state_t;

   top_state_t s_reg;
   top_state_t s_next;

   logic [`MK_NUM_CH-1:0] offOk;

   // ----------------------------------------------------------------------
   // system units to samples: hundredths times ratio, rounded, clamped
   // ----------------------------------------------------------------------
   function automatic logic [CNT_W-1:0] toSamples(input logic [31:0] units,
                                                  input logic [RATIO_W-1:0] ratio,
                                                  input logic atLeastOne);
      logic [39:0] prod;
      logic [39:0] q;
      logic [CNT_W-1:0] r;
      prod = 40'(units) * 40'((ratio == '0) ? RATIO_W'(1) : ratio) + `MK_UNIT_HALF;
      q = prod / `MK_UNIT_DIV;                                      // [RULE_10]
      r = (q > 40'(`MK_CNT_MAX)) ? `MK_CNT_MAX : q[CNT_W-1:0];      // [RULE_09] [RULE_14]
      if (atLeastOne && r == '0) r = CNT_W'(1);                     // [RULE_11] [RULE_14]
      return r;
   endfunction : toSamples

   // ----------------------------------------------------------------------
   // register access
   // ----------------------------------------------------------------------
   always_comb begin
      logic        req;
      logic        wr;
      logic [2:0]  ch;
      logic [3:0]  sub;
      logic        p;
      logic        full;
      logic        rejEv;
      logic        rejClr;
      logic [31:0] rd;
      s_next = s_reg;
      req    = wb_cyc_i & wb_stb_i & ~s_reg.ack;
      wr     = req & wb_we_i;
      ch     = wb_adr_i[6:4];
      sub    = wb_adr_i[3:0];
      p      = wb_adr_i[3];
      full   = (wb_sel_i == 4'hf);
      rejEv  = 1'b0;
      rejClr = 1'b0;
      rd     = 32'h00000000;
      s_next.ack = req;
      if (wb_adr_i < `MK_PAT_BASE) begin
         case (sub)
            `MK_OFS_CTRL: begin
               rd = {27'h0, s_reg.neg[ch], 2'h0, s_reg.mode[ch]};
               if (wr && wb_sel_i[0]) begin
                  s_next.neg[ch] = wb_dat_i[`MK_CTRL_POL_BIT];     // [RULE_15]
                  // refused modes leave the old one in place and raise a flag
                  if (wb_dat_i[1:0] == 2'h3 ||
                      (wb_dat_i[1:0] == 2'h0 && !offOk[ch])) begin  // [RULE_07] [RULE_08]
                     rejEv = 1'b1;
                  end else begin
                     s_next.mode[ch] = marker_pkg::mode_t'(wb_dat_i[1:0]);
                  end
               end
            end
            `MK_OFS_OFFSET: begin
               rd = 32'(s_reg.offset[ch]);
               if (wr && full)
                  s_next.offset[ch] = toSamples(wb_dat_i, s_reg.ratio[ch / 3], 1'b0);
            end
            `MK_OFS_WIDTH: begin
               rd = 32'(s_reg.width[ch]);
               if (wr && full)
                  s_next.width[ch] = toSamples(wb_dat_i, s_reg.ratio[ch / 3], 1'b1);
            end
            `MK_OFS_CYCLE: begin
               rd = 32'(s_reg.cycle[ch]);
               if (wr && full)
                  s_next.cycle[ch] = toSamples(wb_dat_i, s_reg.ratio[ch / 3], 1'b1);
            end
            default: rd = 32'h00000000;
         endcase
      end else if (wb_adr_i < `MK_STATUS) begin
         if (!wb_adr_i[2]) begin
            rd = {16'h0, 8'(s_reg.ratio[p]), 6'h0, s_reg.res[p]};
            if (wr && wb_sel_i[0] && wb_dat_i[1:0] != 2'h3)
               s_next.res[p] = marker_pkg::res_t'(wb_dat_i[1:0]);
            if (wr && wb_sel_i[1])
               s_next.ratio[p] = wb_dat_i[`MK_PCFG_RATIO_LSB +: RATIO_W];
         end else begin
            rd = 32'(s_reg.plen[p]);
            if (wr && full)
               s_next.plen[p] = (wb_dat_i[CNT_W-1:0] == '0) ? CNT_W'(1) : wb_dat_i[CNT_W-1:0];
         end
      end else if (wb_adr_i == `MK_STATUS) begin
         rd = {23'h0, s_reg.rej, 2'h0, markerOut};
         rejClr = wr & wb_sel_i[1] & wb_dat_i[`MK_STAT_REJ_BIT];
      end
      // a refusal in the same cycle as the clear still shows
      s_next.rej = (s_reg.rej & ~rejClr) | rejEv;
      if (req) s_next.rdata = rd;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s_reg        <= '0;
         s_reg.width  <= {`MK_NUM_CH{`MK_RST_WIDTH}};               // [RULE_11]
         s_reg.cycle  <= {`MK_NUM_CH{`MK_RST_CYCLE}};               // [RULE_14]
         s_reg.offset <= {`MK_NUM_CH{`MK_RST_OFFSET}};              // [RULE_09]
         s_reg.plen   <= {`MK_NUM_PAT{`MK_RST_PLEN}};
         s_reg.ratio  <= {`MK_NUM_PAT{`MK_RST_RATIO}};
      end else begin
         s_reg <= s_next;
      end
   end

   assign wb_ack_o = s_reg.ack;
   assign wb_dat_o = s_reg.rdata;

   // ----------------------------------------------------------------------
   // marker channels, pattern A on 0..2 and B on 3..5
   // ----------------------------------------------------------------------
   for (genvar c = 0; c < `MK_NUM_CH; c++) begin : g_ch                // [RULE_01]
      localparam int PAT = c / `MK_PER_PAT;
      localparam int IDX = c % `MK_PER_PAT;
      assign offOk[c] = (s_reg.res[PAT] == marker_pkg::RES_14) ||
                        (s_reg.res[PAT] == marker_pkg::RES_15 && IDX == 0); // [RULE_06] [RULE_07]
      marker_channel #(.CNT_W(CNT_W)) u_ch (
         .sys_clk    (sys_clk),
         .rstn       (rstn),
         .sampleEn   (sampleEn),
         .patStart   (patStart[PAT]),                              // [RULE_19]
         .storedBit  (storedBits[c]),
         .mode       (s_reg.mode[c]),
         .offAllowed (offOk[c]),
         .negPol     (s_reg.neg[c]),
         .offset     (s_reg.offset[c]),
         .width      (s_reg.width[c]),
         .cycle      (s_reg.cycle[c]),
         .patLen     (s_reg.plen[PAT]),
         .markerOut  (markerOut[c])                                // [RULE_16]
      );
   end

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   AST_ACK_ONE_CYCLE: assert property (@(posedge sys_clk) disable iff (!rstn)
      wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
   AST_ACK_NEXT: assert property (@(posedge sys_clk) disable iff (!rstn)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("request not answered");
   AST_REFUSE_OFF: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_07]
      wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && wb_adr_i < `MK_PAT_BASE
      && wb_adr_i[3:0] == `MK_OFS_CTRL && wb_dat_i[1:0] == 2'h0 && !offOk[wb_adr_i[6:4]]
      |=> s_reg.rej && $stable(s_reg.mode)) else $error("forbidden off mode accepted");
   AST_POL_WRITE: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_17]
      wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && wb_adr_i < `MK_PAT_BASE
      && wb_adr_i[3:0] == `MK_OFS_CTRL
      |=> s_reg.neg[$past(wb_adr_i[6:4])] == $past(wb_dat_i[`MK_CTRL_POL_BIT]))
      else $error("polarity write lost");

endmodule : waveform_marker_pulse_gen
`default_nettype wire

// *** sim/trigger_receiver.sv ***
// far-side trigger receiver: captures marker levels once per waveform sample
`timescale 1ns/100ps
`default_nettype none
module trigger_receiver (
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   input  wire logic       sampleEn,
   input  wire logic [5:0] markerOut,
   output logic            seenStb,
   output logic      [5:0] seenVal
);
   logic sampleDly;
   // markers settle one edge after the strobe, so capture one edge later
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sampleDly <= 1'b0;
         seenStb   <= 1'b0;
         seenVal   <= 6'h00;
      end else begin
         sampleDly <= sampleEn;
         seenStb   <= sampleDly;
         if (sampleDly) begin
            seenVal <= markerOut;
         end
      end
   end
endmodule : trigger_receiver
`default_nettype wire

// *** sim/waveform_marker_pulse_gen_tb.sv ***
// self-checking bench of the marker pulse generator
`timescale 1ns/100ps
`default_nettype none
module waveform_marker_pulse_gen_tb;
   logic        sys_clk, rstn, cyc, stb, we, ack, sampleEn, seenStb;
   logic [7:0]  adr, lfsr;
   logic [3:0]  sel;
   logic [31:0] datI, datO;
   logic [1:0]  patStart;
   logic [5:0]  storedBits, markerOut, seenVal, lastMk;
   logic [31:0] rdQ[$];
   logic [5:0]  mkQ[$];
   int          num_errors, checks_done, cycles;
   int          mode[6] = '{default: 0};
   bit          neg[6] = '{default: 0};
   longint      offs[6] = '{default: 0};
   longint      wid[6] = '{default: 1};
   longint      cycLen[6] = '{default: 1};
   longint      plen[2] = '{default: 1};
   longint      ratio[2] = '{default: 1};
   longint      cnt[2] = '{default: 0};
   int          res[2] = '{default: 0};
   bit          started[2] = '{default: 0};
   bit          rej;

   waveform_marker_pulse_gen dut_u (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI),
      .wb_dat_o(datO), .wb_ack_o(ack), .sampleEn(sampleEn), .patStart(patStart),
      .storedBits(storedBits), .markerOut(markerOut));
   trigger_receiver rx_u (.sys_clk(sys_clk), .rstn(rstn), .sampleEn(sampleEn),
      .markerOut(markerOut), .seenStb(seenStb), .seenVal(seenVal));

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // ---------------------------------------------------------------
   // reference model and drivers
   // ---------------------------------------------------------------
   function automatic logic [7:0] nextRand(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : nextRand
   function automatic bit offOk(input int ch);
      return res[ch / 3] == 0 || (res[ch / 3] == 1 && ch % 3 == 0);
   endfunction : offOk
   function automatic longint toSamp(input int p, input logic [31:0] v, input bit mn);
      longint s;
      s = (longint'(v) * ratio[p] + 50) / 100;
      if (s > 64'hffffff) s = 64'hffffff;
      if (mn && s < 1) s = 1;
      return s;
   endfunction : toSamp
   function automatic logic [5:0] expMarks(input logic [5:0] bits);
      logic [5:0] e;
      longint     n, per, ph;
      for (int ch = 0; ch < 6; ch++) begin
         n = cnt[ch / 3];
         per = (mode[ch] == 2) ? plen[ch / 3] : cycLen[ch];
         ph = (n - offs[ch]) % per;
         if (mode[ch] == 0) e[ch] = offOk(ch) ? bits[ch] ^ neg[ch] : neg[ch];
         else e[ch] = (started[ch / 3] && n >= offs[ch] && ph < wid[ch]) ^ neg[ch];
      end
      return e;
   endfunction : expMarks
   task automatic miss(input string m);
      $display("mismatch at %0t: %s", $time, m);
      num_errors++;
   endtask : miss
   task automatic results();
      if (rdQ.size() + mkQ.size() != 0) miss("results never appeared");
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results
   task automatic wb(input bit w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      datI <= d;
      sel <= s;
      // no limit of its own: the cycle ceiling ends a hung wait
      do begin
         @(posedge sys_clk);
      end while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rdQ.push_back(e);
      wb(1'b0, a, 32'h0, 4'hf);
   endtask : rd
   task automatic setCh(input int ch, input int m, input bit ng, input logic [31:0] o,
                        input logic [31:0] w, input logic [31:0] c);
      wb(1'b1, 8'(ch * 16), {27'h0, ng, 2'b00, 2'(m)}, 4'hf);
      wb(1'b1, 8'(ch * 16 + 4), o, 4'hf);
      wb(1'b1, 8'(ch * 16 + 8), w, 4'hf);
      wb(1'b1, 8'(ch * 16 + 12), c, 4'hf);
      if (m == 3 || (m == 0 && !offOk(ch))) rej = 1'b1;
      else mode[ch] = m;
      neg[ch] = ng;
      offs[ch] = toSamp(ch / 3, o, 1'b0);
      wid[ch] = toSamp(ch / 3, w, 1'b1);
      cycLen[ch] = toSamp(ch / 3, c, 1'b1);
   endtask : setCh
   task automatic sample(input logic [1:0] ps);
      lfsr = nextRand(lfsr);
      for (int p = 0; p < 2; p++) begin
         if (ps[p]) cnt[p] = 0;
         else cnt[p]++;
         if (ps[p]) started[p] = 1'b1;
      end
      lastMk = expMarks(lfsr[5:0]);
      mkQ.push_back(lastMk);
      @(posedge sys_clk);
      sampleEn <= 1'b1;
      patStart <= ps;
      storedBits <= lfsr[5:0];
      @(posedge sys_clk);
      sampleEn <= 1'b0;
      patStart <= 2'b00;
   endtask : sample

   // oldest note is matched against each result as it shows up
   always @(posedge sys_clk) begin
      cycles++;
      if (ack === 1'b1 && we === 1'b0 && rdQ.size() > 0) begin
         checks_done++;
         if (datO !== rdQ[0]) miss($sformatf("read %h want %h", datO, rdQ[0]));
         void'(rdQ.pop_front());
      end
      if (seenStb === 1'b1 && mkQ.size() > 0) begin
         checks_done++;
         if (seenVal !== mkQ[0]) miss($sformatf("markers %b want %b", seenVal, mkQ[0]));
         void'(mkQ.pop_front());
      end
      if (cycles == 20000) begin
         miss("run did not finish");
         results();
      end
   end

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      {rstn, cyc, stb, we, adr, sel, datI, sampleEn, patStart, storedBits} = '0;
      lfsr = 8'h24;
      lastMk = 6'h00;
      repeat (6) @(posedge sys_clk);
      rstn <= 1'b1;
      for (int ch = 0; ch < 6; ch++) begin
         rd(8'(ch * 16), 32'h0);
         rd(8'(ch * 16 + 4), 32'h0);
         rd(8'(ch * 16 + 8), 32'h1);
         rd(8'(ch * 16 + 12), 32'h1);
      end
      rd(8'h60, 32'h100);
      wb(1'b1, 8'h80, 32'h5a, 4'hf);
      rd(8'h80, 32'h0);
      setCh(0, 0, 1'b1, 0, 100, 100);
      repeat (6) sample(2'b00);
      wb(1'b1, 8'h64, 32'd7, 4'hf);
      plen[0] = 7;
      wb(1'b1, 8'h6c, 32'd4, 4'hf);
      plen[1] = 4;
      setCh(1, 1, 1'b0, 200, 200, 500);
      setCh(2, 2, 1'b0, 100, 900, 100);
      setCh(3, 1, 1'b1, 0, 100, 300);
      setCh(4, 2, 1'b0, 0, 200, 100);
      sample(2'b01);
      repeat (9) sample(2'b00);
      sample(2'b10);
      repeat (5) sample(2'b00);
      sample(2'b01);
      repeat (8) sample(2'b00);
      wb(1'b1, 8'h60, 32'h101, 4'hf);
      res[0] = 1;
      setCh(0, 0, 1'b1, 0, 100, 100);
      setCh(1, 0, 1'b0, 200, 200, 500);
      rd(8'h70, {23'h0, rej, 2'b00, lastMk});
      wb(1'b1, 8'h70, 32'h100, 4'h2);
      rej = 1'b0;
      rd(8'h70, {23'h0, rej, 2'b00, lastMk});
      setCh(4, 3, 1'b0, 0, 200, 100);
      rd(8'h70, {23'h0, rej, 2'b00, lastMk});
      wb(1'b1, 8'h70, 32'h100, 4'h2);
      rej = 1'b0;
      wb(1'b1, 8'h68, 32'h102, 4'hf);
      res[1] = 2;
      wb(1'b1, 8'h68, 32'h103, 4'hf);
      rd(8'h68, 32'h102);
      setCh(3, 0, 1'b1, 0, 100, 300);
      repeat (4) sample(2'b00);
      rd(8'h70, {23'h0, rej, 2'b00, lastMk});
      wb(1'b1, 8'h60, 32'h301, 4'hf);
      ratio[0] = 3;
      setCh(0, 1, 1'b0, 150, 0, 32'hffffffff);
      rd(8'h04, 32'd5);
      rd(8'h08, 32'd1);
      rd(8'h0c, 32'hffffff);
      wb(1'b1, 8'h04, 32'd900, 4'h3);
      rd(8'h04, 32'd5);
      sample(2'b01);
      repeat (7) sample(2'b00);
      repeat (8) @(posedge sys_clk);
      results();
   end
endmodule : waveform_marker_pulse_gen_tb
`default_nettype wire
